/* dv/tac_link_chk.sv */
// Link checker: tag answers and reader command order
`timescale 1ns/1ps
`default_nettype none
module tac_link_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmdStb,
  input wire tac_pkg::tac_op_t cmdOp,
  input wire logic [7:0] cmdArg,
  input wire logic tagAnsStb,
  input wire logic [7:0] tagAnsId,
  input wire logic rspStb,
  input wire tac_pkg::tac_rsp_t rspKind,
  input wire logic [7:0] rspId,
  input wire logic rspCrcOk
);
  // A single answer with bad CRC is folded into MANY so one register covers both collisions
  tac_pkg::tac_op_t lastOp, next_lastOp;
  tac_pkg::tac_rsp_t lastKind, next_lastKind;
  logic [7:0] lastId, next_lastId;
  logic [3:0] slotPrev, next_slotPrev;

  always_comb begin
    next_lastOp = lastOp;
    next_lastKind = lastKind;
    next_lastId = lastId;
    next_slotPrev = slotPrev;
    if (rspStb) begin
      next_lastOp = cmdOp;
      next_lastKind = rspKind;
      next_lastId = rspId;
      if (rspKind == tac_pkg::RSP_ONE && !rspCrcOk) begin
        next_lastKind = tac_pkg::RSP_MANY;
      end
    end
    if (cmdStb && cmdOp == tac_pkg::OP_SLOT_ZERO_POLL) begin
      next_slotPrev = 4'h0;
    end else if (cmdStb && cmdOp == tac_pkg::OP_SLOT_MARK) begin
      next_slotPrev = cmdArg[3:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lastOp <= tac_pkg::OP_COMPLETION;
      lastKind <= tac_pkg::RSP_NONE;
      lastId <= 8'h00;
      slotPrev <= 4'h0;
    end else begin
      lastOp <= next_lastOp;
      lastKind <= next_lastKind;
      lastId <= next_lastId;
      slotPrev <= next_slotPrev;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_ans_after_cmd: assert property (tagAnsStb |-> $past(cmdStb))
    else $error("tag answer without a command");
  chk_poll_nib_zero: assert property (tagAnsStb &&
    cmdOp == tac_pkg::OP_SLOT_ZERO_POLL |-> tagAnsId[3:0] == 4'h0)
    else $error("poll answer with nonzero nibble");
  chk_mark_nib_match: assert property (tagAnsStb &&
    cmdOp == tac_pkg::OP_SLOT_MARK |-> tagAnsId[3:0] == cmdArg[3:0])
    else $error("slot answer in wrong slot");
  chk_silence_restart: assert property (cmdStb &&
    lastOp == tac_pkg::OP_START_INV && lastKind == tac_pkg::RSP_NONE
    |-> cmdOp == tac_pkg::OP_START_INV)
    else $error("no restart after silence");
  chk_many_to_poll: assert property (cmdStb &&
    lastOp == tac_pkg::OP_START_INV && lastKind == tac_pkg::RSP_MANY
    |-> cmdOp == tac_pkg::OP_SLOT_ZERO_POLL)
    else $error("collision not followed by poll");
  chk_single_select: assert property (cmdStb &&
    lastOp <= tac_pkg::OP_SLOT_MARK && lastKind == tac_pkg::RSP_ONE
    |-> cmdOp == tac_pkg::OP_TAG_SELECT && cmdArg == lastId)
    else $error("single answer not selected");
  // After slot 15 the stored identifiers are selected in turn
  chk_collide_no_sel: assert property (cmdStb &&
    lastOp <= tac_pkg::OP_SLOT_MARK && lastKind == tac_pkg::RSP_MANY &&
    !(lastOp == tac_pkg::OP_SLOT_MARK && slotPrev == 4'hf)
    |-> cmdOp != tac_pkg::OP_TAG_SELECT)
    else $error("select after collision");
  chk_slot_ascend: assert property (cmdStb &&
    cmdOp == tac_pkg::OP_SLOT_MARK |-> cmdArg[3:0] == slotPrev + 4'h1)
    else $error("slot mark out of order");
  chk_next_cmd_due: assert property (rspStb &&
    cmdOp != tac_pkg::OP_START_INV |=> !cmdStb ##[1:39] cmdStb)
    else $error("next command too early or missing");
endmodule
`default_nettype wire

/* dv/tag_anticollision_sequencer_tb.sv */
// Bench: reader and tag face to face, plus a lone tag driven directly
`timescale 1ns/1ps
`default_nettype none
module tag_anticollision_sequencer_tb;
  localparam tac_pkg::tac_op_t INV = tac_pkg::OP_START_INV;
  localparam tac_pkg::tac_op_t SZP = tac_pkg::OP_SLOT_ZERO_POLL;
  localparam tac_pkg::tac_op_t MRK = tac_pkg::OP_SLOT_MARK;
  localparam tac_pkg::tac_op_t SEL = tac_pkg::OP_TAG_SELECT;
  localparam tac_pkg::tac_rsp_t RN = tac_pkg::RSP_NONE;
  localparam tac_pkg::tac_rsp_t R1 = tac_pkg::RSP_ONE;
  logic mclk, rst_n, run, relDeact, accAck, fieldOn, accReq, busy, ans;
  logic [7:0] accId, ansId, id2, tid1, tid2;
  logic [2:0] st1, st2;
  int mismatches, n_checks, nchg;
  tac_link_if lnk();
  tac_link_if lnk2();
  tac_tag i_tac_tag (.mclk(mclk), .rst_n(rst_n), .link(lnk.tag),
    .fieldOn(fieldOn), .tagState(st1), .tagId(tid1));
  tac_tag #(.SEED(16'h5a3c)) i_tac_tag_b (.mclk(mclk), .rst_n(rst_n),
    .link(lnk2.tag), .fieldOn(fieldOn), .tagState(st2), .tagId(tid2));
  tac_reader i_tac_reader (.mclk(mclk), .rst_n(rst_n), .link(lnk.reader),
    .run(run), .relDeact(relDeact), .accAck(accAck), .accReq(accReq),
    .accId(accId), .busy(busy));
  tac_link_chk i_tac_link_chk (.mclk(mclk), .rst_n(rst_n),
    .cmdStb(lnk.cmdStb), .cmdOp(lnk.cmdOp), .cmdArg(lnk.cmdArg),
    .tagAnsStb(lnk.tagAnsStb), .tagAnsId(lnk.tagAnsId),
    .rspStb(lnk.rspStb), .rspKind(lnk.rspKind), .rspId(lnk.rspId),
    .rspCrcOk(lnk.rspCrcOk));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [7:0] seen, ex);
    n_checks++;
    if (seen !== ex) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Lone tag: one command pulse, answer taken in the cycle it stands
  task automatic tcmd(input tac_pkg::tac_op_t op, input logic [7:0] arg);
    lnk2.cmdOp = op;
    lnk2.cmdArg = arg;
    lnk2.cmdStb = 1'b1;
    @(posedge mclk);
    #1 lnk2.cmdStb = 1'b0;
    ans = lnk2.tagAnsStb;
    @(posedge mclk);
    #1;
  endtask

  // Bench plays the air: drives one scripted outcome per command, id from the tag answer when tg is set
  task automatic rcmd(input tac_pkg::tac_op_t op, input logic [7:0] arg,
      input tac_pkg::tac_rsp_t kind, input logic [7:0] id, input logic tg);
    int n;
    n = 0;
    while (lnk.cmdStb !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("cmdStb", {7'h0, lnk.cmdStb}, 8'h01);
    chk("cmdOp", {5'h0, lnk.cmdOp}, {5'h0, op});
    if (op != INV) chk("cmdArg", lnk.cmdArg, arg);
    @(posedge mclk);
    #1 ans = lnk.tagAnsStb;
    ansId = lnk.tagAnsId;
    lnk.rspKind = kind;
    lnk.rspId = tg ? lnk.tagAnsId : id;
    lnk.rspCrcOk = (id != 8'h57);
    lnk.rspStb = 1'b1;
    @(posedge mclk);
    #1 lnk.rspStb = 1'b0;
  endtask

  task automatic acc(input logic [7:0] id);
    int n;
    n = 0;
    while (accReq !== 1'b1 && n < 50) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("accReq", {7'h0, accReq}, 8'h01);
    chk("accId", accId, id);
    accAck = 1'b1;
    @(posedge mclk);
    #1 accAck = 1'b0;
  endtask

  initial begin
    #100000;
    mismatches++;
    finish_test();
  end

  initial begin
    {rst_n, run, relDeact, accAck, lnk2.cmdStb, lnk.rspStb} = 6'h00;
    {lnk2.cmdArg, lnk.rspId, lnk.rspCrcOk} = 17'h00000;
    nchg = 0;
    fieldOn = 1'b1;
    lnk2.cmdOp = INV;
    lnk.rspKind = RN;
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'b1;
    @(posedge mclk);
    #1 tcmd(SZP, 8'h00);
    chk("readyPoll", {7'h0, ans}, 8'h00);
    tcmd(MRK, {4'h0, tid2[3:0]});
    chk("readyMark", {7'h0, ans}, 8'h00);
    tcmd(INV, 8'h00);
    chk("invAns", {7'h0, ans}, 8'h01);
    chk("invId", lnk2.tagAnsId, tid2);
    chk("invState", {5'h0, st2}, 8'h02);
    for (int i = 0; i < 24; i++) begin
      id2 = tid2;
      tcmd(SZP, 8'h00);
      nchg += int'(tid2 !== id2);
      chk("pollAns", {7'h0, ans}, {7'h0, tid2[3:0] == 4'h0});
      chk("idHigh", {4'h0, tid2[7:4]}, {4'h0, id2[7:4]});
    end
    chk("nibRedraw", {7'h0, nchg > 0}, 8'h01);
    tcmd(MRK, {4'h0, tid2[3:0]});
    chk("markHit", {7'h0, ans}, 8'h01);
    tcmd(MRK, {4'h0, tid2[3:0] + 4'h1});
    chk("markMiss", {7'h0, ans}, 8'h00);
    tcmd(SEL, tid2);
    for (int k = 0; k < 3; k++) begin
      tcmd(tac_pkg::tac_op_t'(k), {4'h0, tid2[3:0]});
      chk("selIgnore", {7'h0, ans}, 8'h00);
    end
    chk("selState", {5'h0, st2}, 8'h03);
    $display("test tag_rules done");
    run = 1'b1;
    rcmd(INV, 8'h00, tac_pkg::RSP_MANY, 8'h00, 1'b0);
    rcmd(SZP, 8'h00, RN, 8'h00, 1'b0);
    for (int s = 1; s < 16; s++) begin
      rcmd(MRK, 8'(s), (s == 5 || s == 7) ? R1 : RN,
        (s == 7) ? 8'h57 : 8'h35, 1'b0);
      if (s == 5) rcmd(SEL, 8'h35, RN, 8'h00, 1'b0);
    end
    rcmd(SEL, 8'h35, RN, 8'h00, 1'b0);
    acc(8'h35);
    rcmd(tac_pkg::OP_DESELECT, 8'h35, RN, 8'h00, 1'b0);
    rcmd(SZP, 8'h00, RN, 8'h00, 1'b0);
    for (int s = 1; s < 16; s++) begin
      rcmd(MRK, 8'(s), RN, 8'h00, 1'b0);
    end
    relDeact = 1'b1;
    rcmd(INV, 8'h00, R1, 8'h00, 1'b1);
    chk("invTagAns", {7'h0, ans}, 8'h01);
    id2 = ansId;
    rcmd(SEL, id2, RN, 8'h00, 1'b0);
    acc(id2);
    rcmd(tac_pkg::OP_COMPLETION, id2, RN, 8'h00, 1'b0);
    chk("tagDeact", {5'h0, st1}, 8'h05);
    chk("tagSelId", tid1, id2);
    rcmd(INV, 8'h00, RN, 8'h00, 1'b0);
    @(posedge lnk.cmdStb);
    #1 run = 1'b0;
    rcmd(INV, 8'h00, RN, 8'h00, 1'b0);
    repeat (4) @(posedge mclk);
    #1 chk("busy", {7'h0, busy}, 8'h00);
    $display("test reader_flow done");
    finish_test();
  end
endmodule
`default_nettype wire

/* hdl/tac_link_if.sv */
// Link between the reader end and one tag end
`timescale 1ns/1ps
`default_nettype none
interface tac_link_if;
  logic cmdStb;
  tac_pkg::tac_op_t cmdOp;
  logic [7:0] cmdArg;
  logic tagAnsStb;
  logic [7:0] tagAnsId;
  // Merged outcome of all tags, formed outside both ends
  logic rspStb;
  tac_pkg::tac_rsp_t rspKind;
  logic [7:0] rspId;
  logic rspCrcOk;

  modport reader (
    output cmdStb, cmdOp, cmdArg,
    input rspStb, rspKind, rspId, rspCrcOk
  );
  modport tag (
    input cmdStb, cmdOp, cmdArg,
    output tagAnsStb, tagAnsId
  );
endinterface
`default_nettype wire

/* hdl/tac_pkg.sv */
// Shared types and constants for the slot-based anticollision link
//
// Overview of operation
// - Start-inventory moves ready tags into inventory
// - Only inventory tags answer poll and slot-mark
// - Ready tags ignore poll and slot-mark
// - Start-inventory loads and returns random identifier
// - Slot-zero poll redraws the slot nibble first
// - Reader starts with start-inventory, repeats on silence
// - Single answer: select, access, deselect (completion if relDeact), restart
// - Collision on start-inventory: begin slotted search
// - Slot zero: store and select single answer
// - Slot marks 1..15 ascending, store singles
// - After slot 15 select, access, release each
// - Collision in pass repeats it, else restart
// - Every slot handles zero, one, many answers
// - Reader may stop once all tags identified
// - Tag answers poll only when nibble is zero
// - Slot-mark answers when parameter equals nibble
// - Slot nibble is identifier bits 3 to 0
// - Selected tag ignores all anticollision commands
package tac_pkg;
  localparam int ID_W = 8;
  localparam int NIB_W = 4;
  localparam int NUM_SLOTS = 16;
  localparam int LFSR_W = 16;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [7:0] ID_RST = 8'h00;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] SLOT_FIRST = 4'h0;
  localparam logic [3:0] SLOT_LAST = 4'hf;

  typedef enum logic [2:0] {
    OP_START_INV,
    OP_SLOT_ZERO_POLL,
    OP_SLOT_MARK,
    OP_TAG_SELECT,
    OP_DESELECT,
    OP_COMPLETION
  } tac_op_t;

  typedef enum logic [1:0] {
    RSP_NONE,
    RSP_ONE,
    RSP_MANY
  } tac_rsp_t;
endpackage

/* hdl/tac_reader.sv */
// Reader end: walks inventory, slots 0..15, then serves found tags
`timescale 1ns/1ps
`default_nettype none
module tac_reader #(
  parameter int SLOTS = tac_pkg::NUM_SLOTS
) (
  input wire logic mclk,
  input wire logic rst_n,
  tac_link_if.reader link,
  input wire logic run,
  input wire logic relDeact,
  input wire logic accAck,
  output logic accReq,
  output logic [7:0] accId,
  output logic busy
);
  if (SLOTS != tac_pkg::NUM_SLOTS) begin : g_slotCheck
    $error("slot count is fixed at 16");
  end

  typedef enum logic [3:0] {
    R_IDLE, R_INIT, R_SLOT, R_SSEL, R_WSEL, R_WACC, R_WREL
  } tac_rstate_t;

  // A single answer that fails decoding is not trusted as silence
  function automatic tac_pkg::tac_rsp_t outcome(
    input tac_pkg::tac_rsp_t kind,
    input logic crcOk
  );
    if (kind == tac_pkg::RSP_ONE && !crcOk) begin
      outcome = tac_pkg::RSP_MANY;
    end else begin
      outcome = kind;
    end
  endfunction

  tac_rstate_t st, next_st;
  logic pend, next_pend;
  logic [3:0] slot, next_slot;
  logic [4:0] nIds, next_nIds;
  logic [4:0] idx, next_idx;
  logic coll, next_coll;
  logic fromInit, next_fromInit;
  logic [7:0] curId, next_curId;
  logic [7:0] ids [0:15];
  logic store;
  logic cmdStb, next_cmdStb;
  tac_pkg::tac_op_t cmdOp, next_cmdOp;
  logic [7:0] cmdArg, next_cmdArg;
  logic next_accReq;
  logic [7:0] next_accId;
  logic next_busy;
  tac_pkg::tac_rsp_t res;
  logic got;

  always_comb begin
    next_st = st;
    next_pend = pend;
    next_slot = slot;
    next_nIds = nIds;
    next_idx = idx;
    next_coll = coll;
    next_fromInit = fromInit;
    next_curId = curId;
    next_cmdStb = 1'b0;
    next_cmdOp = cmdOp;
    next_cmdArg = cmdArg;
    next_accReq = accReq;
    next_accId = accId;
    next_busy = (st != R_IDLE);
    store = 1'b0;
    res = outcome(link.rspKind, link.rspCrcOk);
    got = pend && link.rspStb;
    if (got) next_pend = 1'b0;
    case (st)
      R_IDLE: begin
        if (run) next_st = R_INIT;
      end
      R_INIT: begin
        if (!pend && !got) begin
          next_cmdStb = 1'b1;
          next_cmdOp = tac_pkg::OP_START_INV;
          next_cmdArg = tac_pkg::ID_RST;
          next_pend = 1'b1;
        end else if (got) begin
          if (res == tac_pkg::RSP_ONE) begin
            next_curId = link.rspId;
            next_fromInit = 1'b1;
            next_st = R_WSEL;
          end else if (res == tac_pkg::RSP_MANY) begin
            next_slot = tac_pkg::SLOT_FIRST;
            next_nIds = '0;
            next_coll = 1'b0;
            next_st = R_SLOT;
          end else if (!run) begin
            next_st = R_IDLE;
          end
        end
      end
      R_SLOT: begin
        if (!pend && !got) begin
          next_cmdStb = 1'b1;
          next_cmdOp = (slot == tac_pkg::SLOT_FIRST) ?
            tac_pkg::OP_SLOT_ZERO_POLL : tac_pkg::OP_SLOT_MARK;
          next_cmdArg = {4'h0, slot};
          next_pend = 1'b1;
        end else if (got) begin
          if (res == tac_pkg::RSP_ONE) begin
            store = 1'b1;
            next_nIds = nIds + 5'h01;
            next_curId = link.rspId;
            next_st = R_SSEL;
          end else begin
            if (res == tac_pkg::RSP_MANY) next_coll = 1'b1;
            if (slot == tac_pkg::SLOT_LAST) begin
              next_idx = '0;
              next_fromInit = 1'b0;
              next_st = R_WSEL;
            end else begin
              next_slot = slot + 4'h1;
            end
          end
        end
      end
      R_SSEL: begin
        // Select right away so the tag leaves the later slots
        if (!pend && !got) begin
          next_cmdStb = 1'b1;
          next_cmdOp = tac_pkg::OP_TAG_SELECT;
          next_cmdArg = curId;
          next_pend = 1'b1;
        end else if (got) begin
          if (slot == tac_pkg::SLOT_LAST) begin
            next_idx = '0;
            next_fromInit = 1'b0;
            next_st = R_WSEL;
          end else begin
            next_slot = slot + 4'h1;
            next_st = R_SLOT;
          end
        end
      end
      R_WSEL: begin
        if (!fromInit && idx == nIds) begin
          if (coll) begin
            next_slot = tac_pkg::SLOT_FIRST;
            next_nIds = '0;
            next_coll = 1'b0;
            next_st = R_SLOT;
          end else begin
            next_st = R_INIT;
          end
        end else if (!pend && !got) begin
          next_cmdStb = 1'b1;
          next_cmdOp = tac_pkg::OP_TAG_SELECT;
          next_cmdArg = fromInit ? curId : ids[idx[3:0]];
          next_pend = 1'b1;
        end else if (got) begin
          next_accId = cmdArg;
          next_accReq = 1'b1;
          next_st = R_WACC;
        end
      end
      R_WACC: begin
        if (accAck) begin
          next_accReq = 1'b0;
          next_st = R_WREL;
        end
      end
      R_WREL: begin
        if (!pend && !got) begin
          next_cmdStb = 1'b1;
          next_cmdOp = relDeact ?
            tac_pkg::OP_COMPLETION : tac_pkg::OP_DESELECT;
          next_cmdArg = accId;
          next_pend = 1'b1;
        end else if (got) begin
          if (fromInit) begin
            next_fromInit = 1'b0;
            next_st = R_INIT;
          end else begin
            next_idx = idx + 5'h01;
            next_st = R_WSEL;
          end
        end
      end
      default: begin
        next_st = R_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= R_IDLE;
      pend <= 1'b0;
      slot <= tac_pkg::SLOT_FIRST;
      nIds <= '0;
      idx <= '0;
      coll <= 1'b0;
      fromInit <= 1'b0;
      curId <= tac_pkg::ID_RST;
      cmdStb <= 1'b0;
      cmdOp <= tac_pkg::OP_START_INV;
      cmdArg <= tac_pkg::ID_RST;
      accReq <= 1'b0;
      accId <= tac_pkg::ID_RST;
      busy <= 1'b0;
    end else begin
      st <= next_st;
      pend <= next_pend;
      slot <= next_slot;
      nIds <= next_nIds;
      idx <= next_idx;
      coll <= next_coll;
      fromInit <= next_fromInit;
      curId <= next_curId;
      cmdStb <= next_cmdStb;
      cmdOp <= next_cmdOp;
      cmdArg <= next_cmdArg;
      accReq <= next_accReq;
      accId <= next_accId;
      busy <= next_busy;
    end
  end

  // Identifier store, one entry per slot at most
  always_ff @(posedge mclk) begin
    if (store) ids[nIds[3:0]] <= link.rspId;
  end

  assign link.cmdStb = cmdStb;
  assign link.cmdOp = cmdOp;
  assign link.cmdArg = cmdArg;
endmodule
`default_nettype wire

/* hdl/tac_tag.sv */
// Tag end: state, random identifier and answer decision
`timescale 1ns/1ps
`default_nettype none
module tac_tag #(
  parameter logic [15:0] SEED = tac_pkg::LFSR_SEED
) (
  input wire logic mclk,
  input wire logic rst_n,
  tac_link_if.tag link,
  input wire logic fieldOn,
  output logic [2:0] tagState,
  output logic [7:0] tagId
);
  typedef enum logic [2:0] {
    T_OFF, T_READY, T_INV, T_SEL, T_DESEL, T_DEACT
  } tac_tstate_t;

  // An all-zero seed locks the shift register at zero for good
  if (SEED == 16'h0000) begin : g_seedCheck
    $error("seed must be nonzero");
  end

  tac_tstate_t st, next_st;
  logic [15:0] lfsr, next_lfsr;
  logic [7:0] id, next_id;
  logic ans, next_ans;
  logic [7:0] ansId, next_ansId;
  logic [3:0] nib;

  always_comb begin
    next_lfsr = lfsr[0] ? ((lfsr >> 1) ^ tac_pkg::LFSR_TAPS) : (lfsr >> 1);
    next_st = st;
    next_id = id;
    next_ans = 1'b0;
    next_ansId = ansId;
    nib = lfsr[3:0];
    if (!fieldOn) begin
      next_st = T_OFF;
    end else if (st == T_OFF) begin
      // Power-up gives a fresh identifier
      next_st = T_READY;
      next_id = lfsr[7:0];
    end else if (link.cmdStb) begin
      case (link.cmdOp)
        tac_pkg::OP_START_INV: begin
          if (st == T_READY || st == T_INV) begin
            next_st = T_INV;
            next_id = lfsr[7:0];
            next_ans = 1'b1;
            next_ansId = lfsr[7:0];
          end
        end
        tac_pkg::OP_SLOT_ZERO_POLL: begin
          if (st == T_INV) begin
            next_id = {id[7:4], nib};
            if (nib == tac_pkg::NIB_ZERO) begin
              next_ans = 1'b1;
              next_ansId = {id[7:4], nib};
            end
          end
        end
        tac_pkg::OP_SLOT_MARK: begin
          if (st == T_INV && link.cmdArg[3:0] == id[3:0]) begin
            next_ans = 1'b1;
            next_ansId = id;
          end
        end
        tac_pkg::OP_TAG_SELECT: begin
          if ((st == T_INV || st == T_DESEL) && link.cmdArg == id) begin
            next_st = T_SEL;
          end else if (st == T_SEL && link.cmdArg != id) begin
            next_st = T_DESEL;
          end
        end
        tac_pkg::OP_DESELECT: begin
          if (st == T_SEL) next_st = T_DESEL;
        end
        tac_pkg::OP_COMPLETION: begin
          if (st == T_SEL) next_st = T_DEACT;
        end
        default: begin
          next_st = st;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= T_OFF;
      lfsr <= SEED;
      id <= tac_pkg::ID_RST;
      ans <= 1'b0;
      ansId <= tac_pkg::ID_RST;
    end else begin
      st <= next_st;
      lfsr <= next_lfsr;
      id <= next_id;
      ans <= next_ans;
      ansId <= next_ansId;
    end
  end

  assign link.tagAnsStb = ans;
  assign link.tagAnsId = ansId;
  assign tagState = st;
  assign tagId = id;
endmodule
`default_nettype wire
